// ### logic/pss_pkg.sv
/*
 pss_pkg: constants shared by the prioritized supply selector.
 Assumes a single 10 MHz clock and a 32-bit AHB-Lite register slave.
*/
package pss_pkg;

    // ------------------------------------------------------------
    // time base and timing counts
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned VALID_TIME_MS = 256;
    localparam int unsigned SOFT_TIME_MS  = 32;
    localparam int unsigned FILT_TIME_US  = 8;
    localparam int unsigned VALID_CYC     = VALID_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFT_CYC      = SOFT_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned FILT_CYC      = FILT_TIME_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
    localparam logic [2:0]  CTRL_RESET   = 3'h0;
    localparam int unsigned ST_QUAL_LSB  = 0;
    localparam int unsigned ST_GATE_LSB  = 4;
    localparam int unsigned ST_OFFL_LSB  = 8;
    localparam int unsigned ST_REVL_LSB  = 12;
    localparam int unsigned ST_SOFT_BIT  = 16;
    localparam int unsigned ST_CAS_BIT   = 17;
    localparam int unsigned ST_EN_BIT    = 18;
    localparam int unsigned ST_SHUTDOWN_N_BIT  = 19;
    localparam int unsigned ST_PIN_LSB   = 20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  OFFL_RESET   = 3'h7;
    localparam logic        SOFT_RESET   = 1'b1;
    localparam logic        CAS_RESET    = 1'b1;

    // switchover sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM  = 4'b0010,
        ST_ON   = 4'b0100,
        ST_OFF  = 4'b1000
    } pss_state_t;

endpackage : pss_pkg

// ### logic/pss_selector.sv
/*
 pss_selector: three-input prioritized supply selector control logic.
 Assumes window comparators, gate-off and reverse-guard comparators and an
 output droop comparator outside; all of them are asynchronous to hclk.
 Registers are reached over AHB-Lite, zero wait states.
*/
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
// Contract
// [R1] supply one connects whenever qualified
// [R2] supply two only while one unqualified
// [R3] supply three only while one, two unqualified
// [R4] qualify after 256 ms continuous window
// [R5] over-limit input invalidates channel
// [R6] under-limit input invalidates channel
// [R7] good flag low when qualified
// [R8] enable low forces all gates off
// [R9] enable high connects best qualified channel
// [R10] good flags keep updating while disabled
// [R11] shutdown disconnects, stops monitoring, clears timers
// [R12] cascade high: all invalid, off, enabled
// [R13] cascade high whenever shutdown asserted
// [R14] cascade low when any qualified, running
// [R15] cascade low whenever enable deasserted; the code holds it high instead while shutdown is asserted
// [R16] system chains cascade into next enable
// [R17] next channel waits for off latch
// [R18] off latch clears on turn-on
// [R19] connect waits for latched reverse guard
// [R20] soft-start first connection, ends 32 ms
// [R21] shutdown rise or droop re-arms soft-start
// [R22] higher qualified supply preempts lower one
// [R23] connected fault filtered for 8 us
// [R24] timers are counters on clock
`timescale 1ns/1ps

module pss_selector
    import pss_pkg::*;
#(
    parameter int unsigned VALID_CYCLES = VALID_CYC,
    parameter int unsigned SOFT_CYCLES  = SOFT_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // window comparators
    input  wire logic        over_limit_in_1,
    input  wire logic        over_limit_in_2,
    input  wire logic        over_limit_in_3,
    input  wire logic        under_limit_in_1,
    input  wire logic        under_limit_in_2,
    input  wire logic        under_limit_in_3,
    // switch feedback comparators
    input  wire logic        gate_off_detector_1,
    input  wire logic        gate_off_detector_2,
    input  wire logic        gate_off_detector_3,
    input  wire logic        reverse_guard_cmp_1,
    input  wire logic        reverse_guard_cmp_2,
    input  wire logic        reverse_guard_cmp_3,
    input  wire logic        out_droop_cmp,
    // control pins
    input  wire logic        enable,
    input  wire logic        shutdown_n,
    // gate drive
    output logic             switch_gate_1,
    output logic             switch_gate_2,
    output logic             switch_gate_3,
    output logic             soft_start,
    // open-drain good flags
    input  wire logic        supply_good_n_1_i,
    input  wire logic        supply_good_n_2_i,
    input  wire logic        supply_good_n_3_i,
    output logic             supply_good_n_1_o,
    output logic             supply_good_n_2_o,
    output logic             supply_good_n_3_o,
    output logic             supply_good_n_1_oe,
    output logic             supply_good_n_2_oe,
    output logic             supply_good_n_3_oe,
    // cascade
    output logic             cascade_out
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NS = 15;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [NS-1:0] filt_next;

    assign raw_in = {shutdown_n, enable, out_droop_cmp,
                     reverse_guard_cmp_3, reverse_guard_cmp_2, reverse_guard_cmp_1,
                     gate_off_detector_3, gate_off_detector_2, gate_off_detector_1,
                     under_limit_in_3, under_limit_in_2, under_limit_in_1,
                     over_limit_in_3, over_limit_in_2, over_limit_in_1};

    // a bit changes only when stages two and three agree
    assign filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);

    // reset shows shutdown, so the first release re-arms soft-start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg   <= raw_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    wire logic [2:0] ov_f   = filt_reg[2:0];
    wire logic [2:0] uv_f   = filt_reg[5:3];
    wire logic [2:0] goff_f = filt_reg[8:6];
    wire logic [2:0] rev_f  = filt_reg[11:9];
    wire logic       droop_f = filt_reg[12];
    wire logic       en_f    = filt_reg[13];
    wire logic       shutdown_n_f  = filt_reg[14];

    // ------------------------------------------------------------
    // qualification timers and fault filters
    // ------------------------------------------------------------
    localparam int unsigned VW = $clog2(VALID_CYCLES + 1);
    localparam int unsigned FW = $clog2(FILT_CYC + 1);
    localparam logic [VW-1:0] VALID_LAST = VW'(VALID_CYCLES - 1);
    localparam logic [FW-1:0] FILT_LAST  = FW'(FILT_CYC - 1);

    logic [2:0]    inhibit_reg;
    logic [2:0]    window_ok, drop, qual_next;
    logic [2:0]    qual_reg;
    logic [VW-1:0] vcnt_reg  [3];
    logic [VW-1:0] vcnt_next [3];
    logic [FW-1:0] fcnt_reg  [3];
    logic [FW-1:0] fcnt_next [3];

    for (genvar c = 0; c < 3; c++) begin : g_chan
        // software inhibit looks like a forced under-limit fault
        assign window_ok[c] = shutdown_n_f & ~ov_f[c] & ~uv_f[c] & ~inhibit_reg[c]; // [R5] [R6] [R11]
        // any loss of window before qualification restarts the count
        assign vcnt_next[c] = (!window_ok[c] || qual_reg[c]) ? '0
                              : vcnt_reg[c] + VW'(1); // [R4] [R24]
        assign fcnt_next[c] = (window_ok[c] || !qual_reg[c]) ? '0
                              : fcnt_reg[c] + FW'(1); // [R23] [R24]
        assign drop[c]      = !window_ok[c] && fcnt_reg[c] == FILT_LAST; // [R23]
        assign qual_next[c] = shutdown_n_f & (qual_reg[c] ? ~drop[c]
                              : (window_ok[c] && vcnt_reg[c] == VALID_LAST)); // [R4] [R11]

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                vcnt_reg[c] <= '0;
                fcnt_reg[c] <= '0;
            end else begin
                vcnt_reg[c] <= vcnt_next[c];
                fcnt_reg[c] <= fcnt_next[c];
            end
        end
    end

    // ------------------------------------------------------------
    // priority selection
    // ------------------------------------------------------------
    logic [2:0] target;
    wire logic  run = en_f & shutdown_n_f; // [R8] [R9] [R11]

    // fixed priority, voltage plays no part
    assign target[0] = run & qual_reg[0]; // [R1]
    assign target[1] = run & qual_reg[1] & ~qual_reg[0]; // [R2]
    assign target[2] = run & qual_reg[2] & ~qual_reg[1] & ~qual_reg[0]; // [R3]

    // ------------------------------------------------------------
    // break-before-make sequencer
    // ------------------------------------------------------------
    pss_state_t state_reg, state_next;
    logic [2:0] sel_reg, sel_next;
    logic [2:0] gate_reg, gate_next;
    logic [2:0] offl_reg, offl_next;
    logic [2:0] revl_reg, revl_next;
    logic [2:0] arm_sel, rev_keep;
    logic       disc;

    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        gate_next  = gate_reg;
        unique case (state_reg)
            ST_IDLE: begin
                // no new channel until every switch is seen off
                if (|target && &offl_reg) begin // [R17]
                    state_next = ST_ARM;
                    sel_next   = target;
                end
            end
            ST_ARM: begin
                if (target != sel_reg) begin
                    state_next = ST_IDLE;
                end else if (|(revl_reg & sel_reg)) begin // [R19]
                    gate_next  = sel_reg;
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                // a better or lost target both take the switch off first
                if (target != sel_reg) begin // [R8] [R22] [R23]
                    gate_next  = '0;
                    state_next = ST_OFF;
                end
            end
            ST_OFF: begin
                if (|(offl_reg & sel_reg)) begin // [R17]
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    assign disc     = state_reg == ST_ON && target != sel_reg;
    assign arm_sel  = (state_reg == ST_ARM) ? sel_reg : 3'h0;
    // off latch: set by detector while undriven, cleared by turn-on
    assign offl_next = ~gate_next & (offl_reg | (~gate_reg & goff_f)); // [R17] [R18]
    // reverse latch lives from arming until the channel is off again
    assign rev_keep  = gate_reg | gate_next | arm_sel;
    assign revl_next = rev_keep & (revl_reg | (arm_sel & rev_f)); // [R19]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            sel_reg   <= '0;
            gate_reg  <= '0;
            offl_reg  <= OFFL_RESET;
            revl_reg  <= '0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            gate_reg  <= gate_next;
            offl_reg  <= offl_next;
            revl_reg  <= revl_next;
        end
    end

    // ------------------------------------------------------------
    // soft-start
    // ------------------------------------------------------------
    localparam int unsigned SW = $clog2(SOFT_CYCLES + 1);
    localparam logic [SW-1:0] SOFT_LAST = SW'(SOFT_CYCLES - 1);

    logic          soft_reg, soft_next, shutdown_n_d_reg;
    logic [SW-1:0] scnt_reg, scnt_next;
    logic          rearm, soft_end;

    assign rearm     = (shutdown_n_f & ~shutdown_n_d_reg) | droop_f; // [R21]
    assign soft_end  = disc | (scnt_reg == SOFT_LAST); // [R20]
    // re-arm wins over termination in the same cycle
    assign soft_next = rearm | (soft_reg & ~soft_end); // [R20] [R21]
    // the 32 ms window runs only while a channel is actually on
    assign scnt_next = (soft_next && !rearm && |gate_reg) ? scnt_reg + SW'(1) : '0; // [R24]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_reg   <= SOFT_RESET;
            scnt_reg   <= '0;
            shutdown_n_d_reg <= 1'b0;
        end else begin
            soft_reg   <= soft_next;
            scnt_reg   <= scnt_next;
            shutdown_n_d_reg <= shutdown_n_f;
        end
    end

    // ------------------------------------------------------------
    // flags and cascade
    // ------------------------------------------------------------
    logic [2:0] good_oe_reg;
    logic       cas_reg, cas_next, qual_any;

    assign qual_any = |qual_reg;
    // shutdown outranks enable when both call for the output
    assign cas_next = !shutdown_n_f ? 1'b1 // [R13]
                    : !en_f ? 1'b0 // [R15]
                    : qual_any ? 1'b0 // [R14]
                    : &offl_reg ? 1'b1 // [R12]
                    : cas_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qual_reg    <= '0;
            good_oe_reg <= '0;
            cas_reg     <= CAS_RESET;
        end else begin
            qual_reg    <= qual_next;
            good_oe_reg <= qual_reg; // [R7] [R10]
            cas_reg     <= cas_next;
        end
    end

    // ------------------------------------------------------------
    // ahb-lite register slave
    // ------------------------------------------------------------
    logic        wp_reg, zero_reg, hready_reg;
    logic [31:0] hrdata_reg, rd_word, st_word;
    logic [2:0]  ctrl_view, pin_view;
    wire logic   ap = hsel & hready & htrans[1];
    wire logic   ap_wr = ap & hwrite & (hsize == HSIZE_WORD) & (haddr[11:0] == ADDR_CTRL);

    // a read right behind a write sees the new control value
    assign ctrl_view = wp_reg ? hwdata[2:0] : inhibit_reg;
    assign pin_view  = {supply_good_n_3_i, supply_good_n_2_i, supply_good_n_1_i};
    assign st_word   = (32'(qual_reg) << ST_QUAL_LSB) | (32'(gate_reg) << ST_GATE_LSB)
                     | (32'(offl_reg) << ST_OFFL_LSB) | (32'(revl_reg) << ST_REVL_LSB)
                     | (32'(soft_reg) << ST_SOFT_BIT) | (32'(cas_reg) << ST_CAS_BIT)
                     | (32'(en_f) << ST_EN_BIT) | (32'(shutdown_n_f) << ST_SHUTDOWN_N_BIT)
                     | (32'(pin_view) << ST_PIN_LSB);
    // unmapped words read as zero and ignore writes
    assign rd_word   = (haddr[11:0] == ADDR_CTRL) ? 32'(ctrl_view)
                     : (haddr[11:0] == ADDR_STATUS) ? st_word : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_reg      <= 1'b0;
            inhibit_reg <= CTRL_RESET;
            hrdata_reg  <= 32'h0000_0000;
            hready_reg  <= 1'b1;
            zero_reg    <= 1'b0;
        end else begin
            wp_reg      <= ap_wr;
            inhibit_reg <= ctrl_view;
            hrdata_reg  <= (ap && !hwrite) ? rd_word : hrdata_reg;
            hready_reg  <= 1'b1;
            zero_reg    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata             = hrdata_reg;
    assign hreadyout          = hready_reg;
    assign hresp              = zero_reg;
    assign switch_gate_1      = gate_reg[0];
    assign switch_gate_2      = gate_reg[1];
    assign switch_gate_3      = gate_reg[2];
    assign soft_start         = soft_reg;
    assign supply_good_n_1_o  = zero_reg;
    assign supply_good_n_2_o  = zero_reg;
    assign supply_good_n_3_o  = zero_reg;
    assign supply_good_n_1_oe = good_oe_reg[0];
    assign supply_good_n_2_oe = good_oe_reg[1];
    assign supply_good_n_3_oe = good_oe_reg[2];
    assign cascade_out        = cas_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_turn_off;
        state_reg == ST_ON ##1 state_reg == ST_OFF;
    endsequence

    sequence s_connect(int i);
        !gate_reg[i] ##1 gate_reg[i];
    endsequence

    chk_gate_one_hot: assert property ($onehot0(gate_reg)) // [R9]
        else $error("more than one gate on");
    chk_gate_en_off: assert property (!en_f |=> gate_reg == 3'h0) // [R8]
        else $error("gate on while disabled");
    chk_prio_two: assert property ($rose(gate_reg[1]) |-> $past(target) == 3'h2) // [R2]
        else $error("channel two connected over channel one");
    chk_prio_three: assert property ($rose(gate_reg[2]) |-> $past(qual_reg[1:0]) == 2'h0) // [R3]
        else $error("channel three connected over higher one");
    chk_shutdown_n_clear: assert property (!shutdown_n_f |=> qual_reg == 3'h0 && vcnt_reg[0] == '0) // [R11]
        else $error("timers run in shutdown");
    chk_good_track: assert property (qual_reg[0] |=> good_oe_reg[0]) // [R7]
        else $error("good flag not driven");
    chk_qual_time: assert property ($rose(qual_reg[0]) |-> $past(vcnt_reg[0]) == VALID_LAST) // [R4]
        else $error("qualified early");
    chk_break_make: assert property (s_connect(0) |-> $past(offl_reg, 2) == 3'h7) // [R17]
        else $error("connect before off latch");
    chk_rev_guard: assert property ($rose(gate_reg[1]) |-> $past(revl_reg[1])) // [R19]
        else $error("connect without reverse guard");
    chk_cas_shutdown_n: assert property (!shutdown_n_f |=> cas_reg) // [R13]
        else $error("cascade low in shutdown");
    chk_cas_en_low: assert property (shutdown_n_f && !en_f |=> !cas_reg) // [R15]
        else $error("cascade high while disabled");
    chk_soft_end: assert property (s_turn_off |-> !soft_reg || $past(rearm)) // [R20]
        else $error("soft-start not ended on disconnect");
    chk_fault_filter: assert property (qual_reg[0] && !window_ok[0] && shutdown_n_f // [R23]
                                       && fcnt_reg[0] != FILT_LAST |=> qual_reg[0])
        else $error("qualification lost before filter");

endmodule : pss_selector

// ### test/pss_partner.sv
/*
 pss_partner: far side of the selector, gate-off and reverse-guard comparators.
 Assumes gates as a vector, bit 0 = channel one, sampled on hclk.
*/
`timescale 1ns/1ps

module pss_partner (
    // clock
    input  wire logic       hclk,
    // gate drive from the selector
    input  wire logic [2:0] gate,
    // comparator answers
    output logic      [2:0] gate_off,
    output logic      [2:0] rev_ok
);
    // ----------------------------------------------------------
    // switch model
    // ----------------------------------------------------------
    logic [2:0] off_d1_reg;
    logic [2:0] off_d2_reg;

    // gate takes three cycles to read as off after it falls, one to read as on again after it rises
    always_ff @(posedge hclk) begin
        off_d1_reg <= ~gate;
        off_d2_reg <= off_d1_reg;
        gate_off   <= off_d2_reg & ~gate;
    end

    // output droops below an input only once every other switch is off
    assign rev_ok[0] = gate_off[1] & gate_off[2];
    assign rev_ok[1] = gate_off[0] & gate_off[2];
    assign rev_ok[2] = gate_off[0] & gate_off[1];
endmodule : pss_partner

// ### test/prioritized_supply_selector_tb.sv
/*
 prioritized_supply_selector_tb: self-checking bench of pss_selector.
 Assumes short counts given as parameters and the pss_partner switch model.
*/
`timescale 1ns/1ps

module prioritized_supply_selector_tb;
    import pss_pkg::*;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    localparam int unsigned VC = 200;
    localparam int unsigned SC = 100;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph = 0;
    logic        enable = 1, shutdown_n = 1, droop = 0;
    logic [31:0] haddr = '0, hwdata = '0;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = HSIZE_WORD, ov = '0, uv = '0;
    wire  logic [31:0] hrdata;
    wire  logic        hreadyout, hresp, soft_start, cascade_out;
    wire  logic [2:0]  g, goff, rv, gd_o, gd_oe, gd_pin;
    logic [63:0] note;
    logic [63:0] rq[$];
    int          miscompares = 0;
    int          tests_run = 0;

    always #50 hclk = ~hclk;
    // good flags are open drain with a pull-up
    assign gd_pin = (gd_oe & gd_o) | ~gd_oe;

    pss_selector #(.VALID_CYCLES(VC), .SOFT_CYCLES(SC)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .over_limit_in_1(ov[0]), .over_limit_in_2(ov[1]), .over_limit_in_3(ov[2]),
        .under_limit_in_1(uv[0]), .under_limit_in_2(uv[1]), .under_limit_in_3(uv[2]),
        .gate_off_detector_1(goff[0]), .gate_off_detector_2(goff[1]), .gate_off_detector_3(goff[2]),
        .reverse_guard_cmp_1(rv[0]), .reverse_guard_cmp_2(rv[1]), .reverse_guard_cmp_3(rv[2]),
        .out_droop_cmp(droop), .enable(enable), .shutdown_n(shutdown_n),
        .switch_gate_1(g[0]), .switch_gate_2(g[1]), .switch_gate_3(g[2]), .soft_start(soft_start),
        .supply_good_n_1_i(gd_pin[0]), .supply_good_n_2_i(gd_pin[1]), .supply_good_n_3_i(gd_pin[2]),
        .supply_good_n_1_o(gd_o[0]), .supply_good_n_2_o(gd_o[1]), .supply_good_n_3_o(gd_o[2]),
        .supply_good_n_1_oe(gd_oe[0]), .supply_good_n_2_oe(gd_oe[1]), .supply_good_n_3_oe(gd_oe[2]),
        .cascade_out(cascade_out)
    );

    pss_partner far_side (.hclk(hclk), .gate(g), .gate_off(goff), .rev_ok(rv));

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
        tests_run++;
        if (a !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, a);
            miscompares++;
        end
    endtask : chk

    // single word transfer; a read notes {mask, expected} for the monitor
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        dph <= ~w;
        if (!w) rq.push_back({m, d});
        do @(posedge hclk); while (hreadyout !== 1'b1);
        dph <= 1'b0;
    endtask : ahb

    // sample on the falling edge so the gate updates have landed
    task automatic wg(input logic [2:0] e, input int lim);
        for (int i = 0; i < lim && g !== e; i++) @(negedge hclk);
        chk("gates", e, g);
    endtask : wg

    task automatic cyc(input int n);
        repeat (n) @(negedge hclk);
    endtask : cyc

    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // read data monitor: oldest note against the data phase
    always @(posedge hclk) begin
        if (dph && hreadyout === 1'b1 && rq.size() > 0) begin
            note = rq.pop_front();
            chk("hrdata", note[31:0], hrdata & note[63:32]);
            chk("hresp", 1'b0, hresp);
        end
    end

    // watchdog, far above the few thousand cycles the sequence needs
    initial begin
        repeat (8000) @(posedge hclk);
        miscompares++;
        give_verdict;
    end

    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    initial begin
        void'($urandom(52));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(VC - 50);
        chk("early", 6'h00, {gd_oe, g});
        wg(3'b001, 300);
        chk("good", 3'b111, gd_oe);
        chk("pins", 3'b000, gd_pin);
        chk("cascade", 1'b0, cascade_out);
        // channel one on: its off latch cleared, its reverse latch held
        ahb(1'b0, ADDR_STATUS, 32'h000C_1617, 32'h007E_7777);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF);
        // a random glitch shorter than the fault filter
        @(posedge hclk);
        uv[0] <= 1'b1;
        repeat (1 + $urandom % 60) @(posedge hclk);
        uv[0] <= 1'b0;
        cyc(100);
        chk("glitch", 3'b001, g);
        for (int i = 0; i < 2; i++) begin
            @(posedge hclk);
            if (i == 0) ov[0] <= 1'b1;
            else uv[0] <= 1'b1;
            cyc(60);
            chk("filter", 3'b001, g);
            wg(3'b010, 200);
            chk("good1", 3'b110, gd_oe);
            @(posedge hclk);
            ov[0] <= 1'b0;
            uv[0] <= 1'b0;
            wg(3'b001, 400);
        end
        ahb(1'b1, ADDR_CTRL, 32'h0000_0003, 32'h0000_0000);
        ahb(1'b0, ADDR_CTRL, 32'h0000_0003, 32'h0000_0007);
        wg(3'b100, 300);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0000, 32'h0000_0000);
        wg(3'b001, 400);
        // enable stands in for the cascade_out of a higher selector
        @(posedge hclk);
        enable <= 1'b0;
        cyc(10);
        chk("dis_gates", 3'b000, g);
        chk("dis_cas", 1'b0, cascade_out);
        chk("dis_good", 3'b111, gd_oe);
        @(posedge hclk);
        enable <= 1'b1;
        wg(3'b001, 40);
        @(posedge hclk);
        shutdown_n <= 1'b0;
        cyc(10);
        chk("sd_gates", 3'b000, g);
        chk("sd_good", 3'b000, gd_oe);
        chk("sd_cas", 1'b1, cascade_out);
        @(posedge hclk);
        shutdown_n <= 1'b1;
        cyc(VC - 50);
        chk("sd_timer", 3'b000, g);
        wg(3'b001, 300);
        chk("soft_on", 1'b1, soft_start);
        cyc(SC + 20);
        chk("soft_end", 1'b0, soft_start);
        // a short output droop re-arms the slow ramp
        @(posedge hclk);
        droop <= 1'b1;
        cyc(10);
        chk("droop_soft", 1'b1, soft_start);
        @(posedge hclk);
        droop <= 1'b0;
        uv <= 3'b111;
        // the disconnect comes before the ramp window runs out
        wg(3'b000, 150);
        chk("soft_disc", 1'b0, soft_start);
        cyc(20);
        chk("idle_cas", 1'b1, cascade_out);
        @(posedge hclk);
        enable <= 1'b0;
        cyc(10);
        chk("dis_cas_hi", 1'b0, cascade_out);
        give_verdict;
    end
endmodule : prioritized_supply_selector_tb
